//--- svl_pkg.sv
/*
 package of the supply level detector control: register offsets, field positions,
 reset values, timing figures and carrier types.
 assumes a single 125 MHz clock domain and a plain strobe register port.
*/
//
// Behaviour
// - ext select 0 feeds divider from supply; 1 routes analog pin to divider.
// - sleep disables both supply detection and converter functions.
// - start written 1 begins comparison at next 8 kHz tap falling edge, about 260 us.
// - busy stays high from the start write until comparison ends.
// - single-shot result ready within 3.125 periods of the 8 kHz tap.
// - end of comparison raises irq only if input below level and mask set.
// - result reads 0 for below the level, 1 for above.
// - result keeps old value until a new comparison completes.
// - reading the second irq request register clears the level irq flag.
// - 4-bit level select picks one of 16 taps, 0.5 V plus n times 150 mV.
// - continuous enable keeps comparator powered, compares each 16 kHz tap period.
// - after continuous enable, busy stays high until settled; software waits.
// - continuous mode raises level irq whenever input falls below the level.
// - clearing continuous enable stops comparisons and powers down the path.
// - analog pin digital input is blocked while used as converter input.
// - control bit3 ext select/result, bit2 start/busy, bit1 continuous, bit0 watchdog off.
// - during power-on reset the supply is checked at level 5 or 9 before release.
// - writing 1 to an irq flag clears only that flag.
// - irq flag sets on request rising edge or at a single-shot end below the level, while its mask is 1.
package svl_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [3:0] SVL_ADDR_CONTROL = 4'h0;
    localparam logic [3:0] SVL_ADDR_LEVEL = 4'h1;
    localparam logic [3:0] SVL_ADDR_IRQ2 = 4'h2;
    localparam logic [3:0] SVL_ADDR_MASK2 = 4'h3;
    localparam logic [3:0] SVL_ADDR_MISC = 4'h4;

    localparam int SVL_BIT_EXT = 3;
    localparam int SVL_BIT_START = 2;
    localparam int SVL_BIT_CONT = 1;
    localparam int SVL_BIT_WDOFF = 0;
    localparam int SVL_BIT_IRQ = 1;
    localparam int SVL_BIT_PULL = 0;

    localparam logic [3:0] SVL_LEVEL_RESET = 4'h5;
    localparam logic [3:0] SVL_LEVEL_POR_LOW = 4'h5;
    localparam logic [3:0] SVL_LEVEL_POR_HIGH = 4'h9;
    localparam logic SVL_WDOFF_RESET = 1'b0;

    // ****************************************
    // timing
    // ****************************************
    localparam int SVL_CLK_MHZ = 125;
    localparam int SVL_MEASURE_NS = 260000;
    localparam int SVL_MEASURE_CYC = SVL_MEASURE_NS * SVL_CLK_MHZ / 1000;
    localparam int SVL_SETTLE_NS = 260000;
    localparam int SVL_SETTLE_CYC = SVL_SETTLE_NS * SVL_CLK_MHZ / 1000;

    typedef struct packed {
        logic [3:0] addr;
        logic [3:0] wdata;
        logic wr;
        logic rd;
    } svl_bus_t;

    typedef struct packed {
        logic power;
        logic sel_ext;
        logic [3:0] tap;
    } svl_analog_t;
endpackage

//--- svl_ctrl.sv
/*
 control of the supply level detector and 4-bit converter.
 assumes prescaler taps and comparator output synchronous to clk; timing counters
 are parameters so simulation can shorten them.
*/
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module svl_ctrl #(
    parameter int MEASURE_CYC = svl_pkg::SVL_MEASURE_CYC,
    parameter int SETTLE_CYC = svl_pkg::SVL_SETTLE_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire svl_pkg::svl_bus_t bus,
    output logic [3:0] rdata,
    input wire logic sleep,
    input wire logic por_active,
    input wire logic por_high_level,
    input wire logic prescaler_tap_8khz,
    input wire logic prescaler_tap_16khz,
    input wire logic comp_above,
    input wire logic analog_port_pin_in,
    output logic analog_port_pin_digital,
    output svl_pkg::svl_analog_t analog,
    output logic pull_remove_analog_pin,
    output logic watchdog_disable,
    output logic por_supply_ok,
    output logic level_irq_flag
);
    // ****************************************
    // registers
    // ****************************************
    typedef enum logic [1:0] {SVL_IDLE, SVL_WAIT_EDGE, SVL_MEASURE, SVL_SETTLE} svl_state_t;
    svl_state_t state;
    logic external_input_select;
    logic continuous_compare_enable;
    logic [3:0] level_select;
    logic level_irq_mask;
    logic compare_result;
    logic [31:0] count;
    logic tap8_q;
    logic tap16_q;
    logic cont_ready;
    logic irq_req;
    logic irq_req_q;
    logic done_below;

    wire logic wr_ctl = bus.wr && bus.addr == svl_pkg::SVL_ADDR_CONTROL;
    wire logic start_req = wr_ctl && bus.wdata[svl_pkg::SVL_BIT_START];
    wire logic tap8_fall = tap8_q && !prescaler_tap_8khz;
    wire logic tap16_rise = !tap16_q && prescaler_tap_16khz;
    wire logic measure_busy = state != SVL_IDLE;
    wire logic meas_done = state == SVL_MEASURE && count == 32'h0000_0000;
    wire logic cont_sample = continuous_compare_enable && cont_ready && tap16_rise && !sleep;
    wire logic irq2_read = bus.rd && bus.addr == svl_pkg::SVL_ADDR_IRQ2;

    // ****************************************
    // software registers
    // ****************************************
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            external_input_select <= 1'b0;
            continuous_compare_enable <= 1'b0;
            watchdog_disable <= svl_pkg::SVL_WDOFF_RESET;
            level_select <= svl_pkg::SVL_LEVEL_RESET;
            level_irq_mask <= 1'b0;
            pull_remove_analog_pin <= 1'b0;
        end
        else if (clk_en && bus.wr)
        begin
            if (bus.addr == svl_pkg::SVL_ADDR_CONTROL)
            begin
                external_input_select <= bus.wdata[svl_pkg::SVL_BIT_EXT];
                continuous_compare_enable <= bus.wdata[svl_pkg::SVL_BIT_CONT];
                watchdog_disable <= bus.wdata[svl_pkg::SVL_BIT_WDOFF];
            end
            else if (bus.addr == svl_pkg::SVL_ADDR_LEVEL)
            begin
                level_select <= bus.wdata;
            end
            else if (bus.addr == svl_pkg::SVL_ADDR_MASK2)
            begin
                level_irq_mask <= bus.wdata[svl_pkg::SVL_BIT_IRQ];
            end
            else if (bus.addr == svl_pkg::SVL_ADDR_MISC)
            begin
                pull_remove_analog_pin <= bus.wdata[svl_pkg::SVL_BIT_PULL];
            end
        end
    end

    // ****************************************
    // edge detection of prescaler taps
    // ****************************************
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            tap8_q <= 1'b0;
            tap16_q <= 1'b0;
        end
        else if (clk_en)
        begin
            tap8_q <= prescaler_tap_8khz;
            tap16_q <= prescaler_tap_16khz;
        end
    end

    // ****************************************
    // measurement sequencer
    // ****************************************
    // settling after continuous enable reuses the busy flag
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state <= SVL_IDLE;
            count <= 32'h0000_0000;
            cont_ready <= 1'b0;
        end
        else if (clk_en)
        begin
            if (sleep)
            begin
                state <= SVL_IDLE;
                cont_ready <= 1'b0;
            end
            else
            begin
                case (state)
                    SVL_IDLE:
                    begin
                        if (start_req)
                        begin
                            state <= SVL_WAIT_EDGE;
                        end
                        else if (continuous_compare_enable && !cont_ready)
                        begin
                            state <= SVL_SETTLE;
                            count <= 32'(SETTLE_CYC - 1);
                        end
                    end
                    SVL_WAIT_EDGE:
                    begin
                        // further start writes are ignored here
                        if (tap8_fall)
                        begin
                            state <= SVL_MEASURE;
                            count <= 32'(MEASURE_CYC - 1);
                        end
                    end
                    SVL_MEASURE:
                    begin
                        if (count == 32'h0000_0000)
                        begin
                            state <= SVL_IDLE;
                        end
                        else
                        begin
                            count <= count - 32'h0000_0001;
                        end
                    end
                    SVL_SETTLE:
                    begin
                        if (!continuous_compare_enable)
                        begin
                            state <= SVL_IDLE;
                        end
                        else if (count == 32'h0000_0000)
                        begin
                            state <= SVL_IDLE;
                            cont_ready <= 1'b1;
                        end
                        else
                        begin
                            count <= count - 32'h0000_0001;
                        end
                    end
                    default:
                    begin
                        state <= SVL_IDLE;
                    end
                endcase
                if (!continuous_compare_enable)
                begin
                    cont_ready <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // result and interrupt request
    // ****************************************
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            compare_result <= 1'b0;
            irq_req <= 1'b0;
            irq_req_q <= 1'b0;
        end
        else if (clk_en)
        begin
            irq_req_q <= irq_req;
            if (meas_done || cont_sample)
            begin
                compare_result <= comp_above;
                irq_req <= !comp_above;
            end
            else if (meas_done == 1'b0 && state == SVL_IDLE && !continuous_compare_enable)
            begin
                irq_req <= 1'b0;
            end
        end
    end

    // single shots need no fresh rising edge, so pulse when below
    assign done_below = (meas_done && !comp_above) || (irq_req && !irq_req_q);

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            level_irq_flag <= 1'b0;
        end
        else if (clk_en)
        begin
            if (done_below && level_irq_mask)
            begin
                level_irq_flag <= 1'b1; // set wins over clear
            end
            else if (irq2_read)
            begin
                level_irq_flag <= 1'b0;
            end
            else if (bus.wr && bus.addr == svl_pkg::SVL_ADDR_IRQ2 && bus.wdata[svl_pkg::SVL_BIT_IRQ])
            begin
                level_irq_flag <= 1'b0;
            end
        end
    end

    // ****************************************
    // power-on check
    // ****************************************
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            por_supply_ok <= 1'b0;
        end
        else if (clk_en)
        begin
            por_supply_ok <= por_active ? comp_above : 1'b1;
        end
    end

    // ****************************************
    // analog controls and read data
    // ****************************************
    always_comb
    begin
        analog.power = !sleep && (por_active || (measure_busy && state != SVL_WAIT_EDGE)
                       || continuous_compare_enable);
        analog.sel_ext = external_input_select && !por_active;
        if (por_active)
        begin
            analog.tap = por_high_level ? svl_pkg::SVL_LEVEL_POR_HIGH : svl_pkg::SVL_LEVEL_POR_LOW;
        end
        else
        begin
            analog.tap = level_select;
        end
    end

    // pin kept low to avoid floating logic input burning current
    assign analog_port_pin_digital = external_input_select ? 1'b0 : analog_port_pin_in;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            rdata <= 4'h0;
        end
        else if (clk_en)
        begin
            rdata <= 4'h0;
            if (bus.rd)
            begin
                if (bus.addr == svl_pkg::SVL_ADDR_CONTROL)
                begin
                    rdata <= {compare_result, measure_busy || start_req, continuous_compare_enable,
                              watchdog_disable};
                end
                else if (bus.addr == svl_pkg::SVL_ADDR_LEVEL)
                begin
                    rdata <= level_select;
                end
                else if (bus.addr == svl_pkg::SVL_ADDR_IRQ2)
                begin
                    rdata <= {2'b00, level_irq_flag, 1'b0};
                end
                else if (bus.addr == svl_pkg::SVL_ADDR_MASK2)
                begin
                    rdata <= {2'b00, level_irq_mask, 1'b0};
                end
                else if (bus.addr == svl_pkg::SVL_ADDR_MISC)
                begin
                    rdata <= {3'b000, pull_remove_analog_pin};
                end
            end
        end
    end
endmodule

//--- svl_ctrl_properties.sv
/*
 port checker of svl_ctrl, bound to the control block.
 assumes one clock domain and an asynchronous active high reset.
*/
`timescale 1ns/1ps
module svl_ctrl_properties (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire svl_pkg::svl_bus_t bus,
    input wire logic [3:0] rdata,
    input wire logic sleep,
    input wire logic por_active,
    input wire logic por_high_level,
    input wire logic comp_above,
    input wire logic analog_port_pin_digital,
    input wire svl_pkg::svl_analog_t analog,
    input wire logic pull_remove_analog_pin,
    input wire logic watchdog_disable,
    input wire logic por_supply_ok,
    input wire logic level_irq_flag
);
    // ****************************************
    // sequences
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    sequence s_wr(logic [3:0] a);
        clk_en && bus.wr && bus.addr == a;
    endsequence
    sequence s_rd(logic [3:0] a);
        clk_en && bus.rd && bus.addr == a;
    endsequence
    sequence s_start;
        s_wr(svl_pkg::SVL_ADDR_CONTROL) ##0 (bus.wdata[svl_pkg::SVL_BIT_START] && !sleep && !por_active);
    endsequence
    // ****************************************
    // properties
    // ****************************************
    property p_pin_block;
        analog.sel_ext |-> !analog_port_pin_digital;
    endproperty
    a_pin_block: assert property (p_pin_block) else $error("pin input not blocked");
    property p_sleep_off;
        sleep |-> !analog.power;
    endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("analog powered in sleep");
    property p_por_tap;
        por_active |-> analog.tap == (por_high_level ? 4'h9 : 4'h5) && !analog.sel_ext;
    endproperty
    a_por_tap: assert property (p_por_tap) else $error("wrong power check level");
    property p_por_ok;
        por_active && clk_en |=> por_supply_ok == $past(comp_above);
    endproperty
    a_por_ok: assert property (p_por_ok) else $error("power check result wrong");
    property p_rdata_idle;
        $past(clk_en) && !$past(bus.rd) |-> rdata == 4'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");
    property p_rd_irq;
        s_rd(svl_pkg::SVL_ADDR_IRQ2) |=> rdata[svl_pkg::SVL_BIT_IRQ] == $past(level_irq_flag);
    endproperty
    a_rd_irq: assert property (p_rd_irq) else $error("flag read back wrong");
    property p_start_busy;
        s_start ##2 s_rd(svl_pkg::SVL_ADDR_CONTROL) |=> rdata[svl_pkg::SVL_BIT_START];
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("busy low after start");
    property p_wdoff;
        s_wr(svl_pkg::SVL_ADDR_CONTROL) |=> watchdog_disable == $past(bus.wdata[svl_pkg::SVL_BIT_WDOFF]);
    endproperty
    a_wdoff: assert property (p_wdoff) else $error("watchdog bit not written");
    property p_pull;
        s_wr(svl_pkg::SVL_ADDR_MISC) |=> pull_remove_analog_pin == $past(bus.wdata[svl_pkg::SVL_BIT_PULL]);
    endproperty
    a_pull: assert property (p_pull) else $error("pull bit not written");
    property p_tap;
        s_wr(svl_pkg::SVL_ADDR_LEVEL) ##1 !por_active |-> analog.tap == $past(bus.wdata);
    endproperty
    a_tap: assert property (p_tap) else $error("divider tap differs from level");
endmodule
bind svl_ctrl svl_ctrl_properties u_svl_ctrl_properties (.clk(clk), .reset(reset), .clk_en(clk_en), .bus(bus),
    .rdata(rdata), .sleep(sleep), .por_active(por_active), .por_high_level(por_high_level),
    .comp_above(comp_above), .analog_port_pin_digital(analog_port_pin_digital), .analog(analog),
    .pull_remove_analog_pin(pull_remove_analog_pin), .watchdog_disable(watchdog_disable),
    .por_supply_ok(por_supply_ok), .level_irq_flag(level_irq_flag));

//--- svl_analog_model.sv
/*
 behavioural comparator, reference and divider.
 assumes input levels in tap steps: step v is above tap n when v > n.
*/
`timescale 1ns/1ps
module svl_analog_model (
    input wire logic clk,
    input wire svl_pkg::svl_analog_t analog,
    input wire logic [4:0] supply_lvl,
    input wire logic [4:0] pin_lvl,
    output logic comp_above
);
    logic junk = 1'b0;
    logic [4:0] v;
    // unpowered output means nothing, so it toggles
    always @(posedge clk)
    begin
        junk <= ~junk;
    end
    assign v = analog.sel_ext ? pin_lvl : supply_lvl;
    assign comp_above = analog.power ? (v > {1'b0, analog.tap}) : junk;
endmodule

//--- testbench.sv
/*
 self-checking bench of svl_ctrl with a behavioural analog side.
 assumes shortened counts: 64 cycle slow tap, 32 cycle fast tap.
*/
`timescale 1ns/1ps
module testbench;
    localparam logic [3:0] A_C = svl_pkg::SVL_ADDR_CONTROL;
    localparam logic [3:0] A_L = svl_pkg::SVL_ADDR_LEVEL;
    localparam logic [3:0] A_I = svl_pkg::SVL_ADDR_IRQ2;
    localparam logic [3:0] A_M = svl_pkg::SVL_ADDR_MASK2;
    logic clk, reset, clk_en, sleep, por_active, por_high_level, pin_in;
    logic comp_above, pin_dig, pull_rm, wd_off, por_ok, irq;
    logic [6:0] pc;
    logic [4:0] supply, pin;
    logic [31:0] lfsr;
    logic [3:0] d, d_out, sar;
    svl_pkg::svl_bus_t bus;
    svl_pkg::svl_analog_t analog;
    integer miscompares, comparisons, m_flag, t0, i;
    svl_ctrl #(.MEASURE_CYC(20), .SETTLE_CYC(20)) u_svl_ctrl (.clk(clk), .reset(reset), .clk_en(clk_en),
        .bus(bus), .rdata(d_out), .sleep(sleep), .por_active(por_active), .por_high_level(por_high_level),
        .prescaler_tap_8khz(pc[5]), .prescaler_tap_16khz(pc[4]), .comp_above(comp_above),
        .analog_port_pin_in(pin_in), .analog_port_pin_digital(pin_dig), .analog(analog),
        .pull_remove_analog_pin(pull_rm), .watchdog_disable(wd_off), .por_supply_ok(por_ok),
        .level_irq_flag(irq));
    svl_analog_model u_svl_analog_model (.clk(clk), .analog(analog), .supply_lvl(supply), .pin_lvl(pin),
        .comp_above(comp_above));
    // ****************************************
    // tasks
    // ****************************************
    function automatic logic [31:0] step(input logic [31:0] s);
        step = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task chk(input logic [3:0] got, input logic [3:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [3:0] v);
        @(posedge clk);
        bus <= {a, v, 2'b10};
        @(posedge clk);
        bus <= '0;
    endtask
    task rd(input logic [3:0] a);
        @(posedge clk);
        bus <= {a, 4'h0, 2'b01};
        @(posedge clk);
        bus <= '0;
        @(posedge clk);
        d = d_out;
    endtask
    task measure(input logic ext, input logic msk, input logic [3:0] lv, input logic w1c);
        integer k;
        integer inp;
        inp = ext ? pin : supply;
        wr(A_M, {2'b00, msk, 1'b0});
        wr(A_L, lv);
        t0 = $time;
        wr(A_C, {ext, 3'b100});
        // look only once the write has landed
        @(negedge clk);
        chk(analog.sel_ext, ext);
        chk(pin_dig, ext ? 1'b0 : pin_in);
        rd(A_C);
        chk(d[2], 1'b1);
        wr(A_C, {ext, 3'b100});
        for (k = 0; k < 80 && d[2]; k++)
            rd(A_C);
        chk(($time - t0) / 8 <= 206, 1'b1);
        chk(d[3], inp > lv);
        m_flag = m_flag | (msk && !(inp > lv));
        supply = ~supply;
        pin = ~pin;
        rd(A_C);
        chk(d[3], inp > lv);
        chk(irq, m_flag);
        if (w1c)
            wr(A_I, 4'h2);
        else
        begin
            rd(A_I);
            chk(d[1], m_flag);
        end
        rd(A_I);
        chk(d, 4'h0);
        m_flag = 0;
    endtask
    task stop_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ****************************************
    // clock, taps, watchdog
    // ****************************************
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
        pc <= pc + 7'h01;
    initial
    begin
        #400000;
        miscompares++;
        stop_test;
    end
    // ****************************************
    // sequence
    // ****************************************
    initial
    begin
        {reset, clk_en, sleep, por_active, por_high_level, pin_in} = 6'b110000;
        bus = '0;
        pc = '0;
        supply = 5'h14;
        pin = 5'h00;
        lfsr = 32'h1c7c_713d;
        {miscompares, comparisons, m_flag} = '0;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        for (i = 0; i < 6; i++)
        begin
            rd(i[3:0] == 4'h5 ? 4'hf : i[3:0]);
            chk(d, i == 1 ? 4'h5 : 4'h0);
        end
        for (i = 0; i < 16; i++)
        begin
            wr(A_L, i[3:0]);
            rd(A_L);
            chk(d, i[3:0]);
        end
        wr(4'hf, 4'hf);
        rd(4'hf);
        chk(d, 4'h0);
        for (i = 0; i < 2; i++)
        begin
            lfsr = step(lfsr);
            @(posedge clk);
            por_active <= 1'b1;
            por_high_level <= i[0];
            supply <= {1'b0, lfsr[3:0]};
            repeat (4) @(posedge clk);
            chk(por_ok, lfsr[3:0] > (i ? 4'h9 : 4'h5));
            por_active <= 1'b0;
        end
        wr(svl_pkg::SVL_ADDR_MISC, 4'h1);
        rd(svl_pkg::SVL_ADDR_MISC);
        chk(d, 4'h1);
        chk(pull_rm, 1'b1);
        for (i = 0; i < 12; i++)
        begin
            lfsr = step(lfsr);
            supply = i == 10 ? 5'h00 : 5'(lfsr[7:4]) + 5'(lfsr[8]);
            pin = 5'(lfsr[12:9]);
            pin_in <= lfsr[13];
            measure(i[0], i[1] | (i > 9), lfsr[3:0] < 4 ? lfsr[3:0] + 4'h4 : lfsr[3:0], i == 10);
        end
        @(posedge clk);
        sleep <= 1'b1;
        repeat (2) @(posedge clk);
        chk(analog.power, 1'b0);
        sleep <= 1'b0;
        supply = 5'h14;
        wr(A_L, 4'hc);
        t0 = $time;
        wr(A_C, 4'h2);
        rd(A_C);
        for (i = 0; i < 20 && d[2]; i++)
            rd(A_C);
        chk(($time - t0) / 8 >= 20, 1'b1);
        chk(analog.power, 1'b1);
        wr(A_L, 4'hf);
        repeat (64) @(posedge clk);
        rd(A_C);
        chk(d[3], 1'b1);
        supply <= 5'h03;
        repeat (64) @(posedge clk);
        rd(A_C);
        chk(d[3], 1'b0);
        chk(irq, 1'b1);
        // a write while frozen must not land
        clk_en <= 1'b0;
        wr(A_L, 4'h0);
        clk_en <= 1'b1;
        rd(A_L);
        chk(d, 4'hf);
        // pin as converter input, four trial levels
        wr(A_C, 4'ha);
        pin <= 5'(lfsr[17:14]);
        sar = 4'h0;
        for (i = 3; i >= 0; i--)
        begin
            wr(A_L, sar | (4'h1 << i));
            repeat (64) @(posedge clk);
            rd(A_C);
            if (d[3] === 1'b1)
                sar = sar | (4'h1 << i);
        end
        chk(sar, pin == 5'h00 ? 4'h0 : 4'(pin - 5'h01));
        wr(A_C, 4'h1);
        repeat (2) @(posedge clk);
        chk(analog.power, 1'b0);
        chk(wd_off, 1'b1);
        stop_test;
    end
endmodule
